/* File: csq_pkg.sv */
// Shared constants and types for the clock source switch sequencer.
`default_nettype none
package csq_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [2:0] ADDR_MODE  = 3'h0;
    localparam logic [2:0] ADDR_STIME = 3'h1;
    localparam logic [2:0] ADDR_CTRL  = 3'h2;
    localparam logic [2:0] ADDR_STAT  = 3'h3;
    localparam logic [2:0] ADDR_SYS   = 3'h4;
    localparam logic [2:0] ADDR_SUB   = 3'h5;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_EXT   = 7;
    localparam int B_OSEL  = 6;
    localparam int B_AMP   = 0;
    localparam int B_MAIN_OSCILLATOR_STOP = 7;
    localparam int B_FIX1  = 6;
    localparam int B_MEN   = 1;
    localparam int B_HSTOP = 0;
    localparam int B_CLS   = 7;
    localparam int B_CSEL  = 6;
    localparam int B_MCS   = 5;
    localparam int B_MSEL  = 4;
    localparam int B_OCS   = 1;
    localparam int B_OSEL1 = 0;
    localparam int B_LSEL  = 0;
    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [2:0] STIME_RST = 3'h7;
    localparam logic [1:0] SW_CYC    = 2'h3;
    localparam logic [7:0] ALL_FLAGS = 8'hff;
    // Elapsed-count exponents of the stabilization flags, flag 7 first.
    localparam logic [4:0] STAB_EXP [8] = '{5'h08, 5'h09, 5'h0a, 5'h0b,
                                            5'h0d, 5'h0f, 5'h11, 5'h12};
    localparam int CNT_W = 19;
    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_HS = 2'h0,
        SRC_MS = 2'h1,
        SRC_XT = 2'h2,
        SRC_LS = 2'h3
    } csq_src_t;
    typedef enum logic [1:0] {
        SW_IDLE = 2'h1,
        SW_WAIT = 2'h2
    } csq_sw_t;
endpackage
`default_nettype wire

/* File: csq_top.sv */
// Clock source enables, stabilization counter and switch sequencer.
// Functional notes
// - Three-bit stabilization-time code; about 102 us at 10 MHz.
// - Clearing main-oscillator-stop starts the crystal when osel is set; setting it stops it unless it drives the clock.
// - Read-only elapsed flags set progressively; software polls them.
// - Main-system-clock select set chooses the high-speed system clock.
// - Main status reads one once in use; check before stopping the crystal.
// - Middle-speed enable starts the middle-speed oscillator; clearing it stops it once it no longer drives the clock.
// - Clearing high-speed stop starts it; software waits 65 us.
// - Clearing CPU clock select puts main system clock on CPU.
// - CPU status reads zero on main clock; check before stopping low-speed.
// - On-chip select zero picks high-speed, one middle-speed; status follows.
// - Low-speed select bit starts the low-speed oscillator, 210 us.
// - CPU clock select set puts subsystem clock on CPU; status one.
// - High-speed stop halts it once it no longer drives the clock.
`timescale 1ns/10ps
`default_nettype none
module csq_top
    import csq_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // Crystal oscillation monitor pin
    input  wire logic       xtal_pulse,
    // Oscillator controls
    output var  logic       xtal_osc_en,
    output var  logic       ext_clk_mode,
    output var  logic       high_amplitude,
    output var  logic       hs_osc_en,
    output var  logic       ms_osc_en,
    output var  logic       ls_osc_en,
    output var  logic [1:0] clk_source
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic             ext;
        logic             osel;
        logic             amp;
        logic [2:0]       stime;
        logic             main_oscillator_stop;
        logic             men;
        logic             hstop;
        logic             csel;
        logic             msel;
        logic             osel1;
        logic             lsel;
        logic             cpu_clock_status;
        logic             main_system_clock_status;
        logic             ocs;
        csq_sw_t          sw;
        logic [1:0]       swcnt;
        logic [2:0]       xs;
        logic             xlvl;
        logic [CNT_W-1:0] cnt;
        logic             xt_en;
        logic             hs_en;
        logic             ms_en;
        logic             ls_en;
        csq_src_t         src;
        logic [7:0]       rdata;
    } csq_state_t;
    csq_state_t st_reg;
    csq_state_t st_next;
    logic [7:0]       flags;
    logic [CNT_W-1:0] limit;
    csq_src_t         cur_src;
    logic             tgt_diff;
    always_comb begin
        // Elapsed flags compare against powers of two; flag 7 is the shortest.
        for (int i = 0; i < 8; i++) begin
            flags[7-i] = st_reg.cnt >= (CNT_W'(1) << STAB_EXP[i]);
        end
        if (st_reg.ext) begin
            flags = ALL_FLAGS;
        end
        limit    = CNT_W'(1) << STAB_EXP[st_reg.stime];
        cur_src  = st_reg.cpu_clock_status ? SRC_LS : st_reg.main_system_clock_status ? SRC_XT :
                   st_reg.ocs ? SRC_MS : SRC_HS;
        tgt_diff = {st_reg.csel, st_reg.msel, st_reg.osel1} !=
                   {st_reg.cpu_clock_status, st_reg.main_system_clock_status, st_reg.ocs};
    end
    always_comb begin
        st_next       = st_reg;
        st_next.rdata = 8'h00;
        // Writes.
        if (reg_wr) begin
            case (reg_addr)
                ADDR_MODE: begin
                    st_next.ext  = reg_wdata[B_EXT];
                    st_next.osel = reg_wdata[B_OSEL];
                    st_next.amp  = reg_wdata[B_AMP];
                end
                ADDR_STIME: st_next.stime = reg_wdata[2:0];
                ADDR_CTRL: begin
                    st_next.main_oscillator_stop = reg_wdata[B_MAIN_OSCILLATOR_STOP];
                    st_next.men   = reg_wdata[B_MEN];
                    st_next.hstop = reg_wdata[B_HSTOP];
                end
                ADDR_SYS: begin
                    st_next.csel  = reg_wdata[B_CSEL];
                    st_next.osel1 = reg_wdata[B_OSEL1];
                    // Guarded so main select cannot change while the CPU runs on or selects the low-speed clock.
                    if (!st_reg.cpu_clock_status && !st_reg.csel) begin
                        st_next.msel = reg_wdata[B_MSEL];
                    end
                end
                ADDR_SUB: st_next.lsel = reg_wdata[B_LSEL];
                default: ;
            endcase
        end
        // Reads, answered in the following cycle only.
        if (reg_rd) begin
            case (reg_addr)
                ADDR_MODE:  st_next.rdata = {st_reg.ext, st_reg.osel, 5'h00, st_reg.amp};
                ADDR_STIME: st_next.rdata = {5'h00, st_reg.stime};
                ADDR_CTRL:  st_next.rdata = {st_reg.main_oscillator_stop, 1'b1, 4'h0, st_reg.men,
                                             st_reg.hstop};
                ADDR_STAT:  st_next.rdata = flags;
                ADDR_SYS:   st_next.rdata = {st_reg.cpu_clock_status, st_reg.csel, st_reg.main_system_clock_status,
                                             st_reg.msel, 2'h0, st_reg.ocs,
                                             st_reg.osel1};
                ADDR_SUB:   st_next.rdata = {7'h00, st_reg.lsel};
                default:    st_next.rdata = 8'h00;
            endcase
        end
        // Crystal monitor: a level counts once the last two stages agree.
        st_next.xs = {st_reg.xs[1:0], xtal_pulse};
        if (st_reg.xs[1] == st_reg.xs[2]) begin
            st_next.xlvl = st_reg.xs[2];
        end
        if (!st_reg.xt_en) begin
            st_next.cnt = '0;
        end else if (st_next.xlvl && !st_reg.xlvl && st_reg.cnt < limit) begin
            st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
        // Status moves only after the selects have differed from the status for the settle time.
        case (st_reg.sw)
            SW_IDLE: begin
                if (tgt_diff) begin
                    st_next.sw    = SW_WAIT;
                    st_next.swcnt = SW_CYC;
                end
            end
            SW_WAIT: begin
                if (!tgt_diff) begin
                    st_next.sw = SW_IDLE;
                end else if (st_reg.swcnt != 2'h0) begin
                    st_next.swcnt = st_reg.swcnt - 2'h1;
                end else begin
                    st_next.cpu_clock_status = st_reg.csel;
                    st_next.main_system_clock_status = st_reg.msel;
                    st_next.ocs = st_reg.osel1;
                    st_next.sw  = SW_IDLE;
                end
            end
            default: st_next.sw = SW_IDLE;
        endcase
        // Enables: the source now driving the clock is never gated off.
        st_next.xt_en = (st_reg.osel && !st_reg.main_oscillator_stop) || cur_src == SRC_XT;
        st_next.hs_en = !st_reg.hstop || cur_src == SRC_HS;
        st_next.ms_en = st_reg.men || cur_src == SRC_MS;
        st_next.ls_en = st_reg.lsel || cur_src == SRC_LS;
        st_next.src   = cur_src;
    end
    always_ff @(posedge mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            st_reg       <= '0;
            st_reg.stime <= STIME_RST;
            st_reg.main_oscillator_stop <= 1'b1;
            st_reg.sw    <= SW_IDLE;
            st_reg.hs_en <= 1'b1;
            st_reg.src   <= SRC_HS;
        end else begin
            st_reg <= st_next;
        end
    end
    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata      = st_reg.rdata;
    assign xtal_osc_en    = st_reg.xt_en;
    assign ext_clk_mode   = st_reg.ext;
    assign high_amplitude = st_reg.amp;
    assign hs_osc_en      = st_reg.hs_en;
    assign ms_osc_en      = st_reg.ms_en;
    assign ls_osc_en      = st_reg.ls_en;
    assign clk_source     = st_reg.src;
    // ************************************************************
    // Checks
    // ************************************************************
    AST_XT_START: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[B_MAIN_OSCILLATOR_STOP] && st_reg.osel
        |=> ##1 xtal_osc_en) else $error("crystal not started");
    AST_MS_EN: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        reg_wr && reg_addr == ADDR_CTRL && reg_wdata[B_MEN] |=> ##1 ms_osc_en)
        else $error("middle oscillator not started");
    AST_HS_EN: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[B_HSTOP] |=> ##1 hs_osc_en)
        else $error("high-speed oscillator not started");
    AST_LS_EN: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        reg_wr && reg_addr == ADDR_SUB && reg_wdata[B_LSEL] |=> ##1 ls_osc_en)
        else $error("low-speed oscillator not started");
    AST_HOLD_SRC: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        (clk_source == SRC_HS |-> hs_osc_en) and (clk_source == SRC_MS |-> ms_osc_en)
        and (clk_source == SRC_LS |-> ls_osc_en) and (clk_source == SRC_XT |-> xtal_osc_en))
        else $error("driving source gated off");
    AST_STAT_LAG: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        $rose(st_reg.cpu_clock_status) |-> $past(st_reg.csel, 4)) else $error("status changed early");
    AST_CPU_SEL: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        st_reg.sw == SW_IDLE && $rose(st_reg.csel) |-> ##[1:6] st_reg.cpu_clock_status)
        else $error("cpu status did not follow");
    AST_MAIN_SEL: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        st_reg.sw == SW_IDLE && $rose(st_reg.msel) |-> ##[1:6] st_reg.main_system_clock_status)
        else $error("main status did not follow");
    AST_RD_STAT: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        reg_rd && reg_addr == ADDR_STAT && st_reg.ext |=> reg_rdata == ALL_FLAGS)
        else $error("external clock flags wrong");
    AST_CNT_CAP: assert property (@(posedge mclk) disable iff (!rst_n_reg)
        st_reg.cnt <= (CNT_W'(1) << STAB_EXP[st_reg.stime]) || $changed(st_reg.stime)
        || $past(st_reg.stime) != st_reg.stime) else $error("counter past limit");
endmodule // csq_top
`default_nettype wire

/* File: test_clock_source_switch_sequencer.sv */
// Self-checking bench for the clock source switch sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_clock_source_switch_sequencer
    import csq_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic       mclk;
    logic       nrst;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       xtal_pulse = 1'b0;
    logic       xtal_osc_en;
    logic       ext_clk_mode;
    logic       high_amplitude;
    logic       hs_osc_en;
    logic       ms_osc_en;
    logic       ls_osc_en;
    logic [1:0] clk_source;
    logic       pulse_on;
    logic [1:0] pcnt = 2'h0;
    logic [7:0] got;
    int         err_count;
    int         checks;
    wire logic [7:0] pins = {xtal_osc_en, ext_clk_mode, high_amplitude, hs_osc_en,
                             ms_osc_en, ls_osc_en, clk_source};
    // Rows hold address, write data and the value that must read back.
    logic [18:0] rows [5] = '{{ADDR_SUB, 8'h01, 8'h01}, {ADDR_STIME, 8'h02, 8'h02},
                              {3'h6, 8'h55, 8'h00}, {ADDR_STAT, 8'h55, 8'h00},
                              {ADDR_MODE, 8'h40, 8'h40}};
    logic [10:0] rst_vals [6] = '{{ADDR_MODE, 8'h00}, {ADDR_STIME, 8'h07},
                                  {ADDR_CTRL, 8'hc0}, {ADDR_STAT, 8'h00},
                                  {ADDR_SYS, 8'h00}, {ADDR_SUB, 8'h00}};
    csq_top dut (
        .mclk           (mclk),
        .nrst           (nrst),
        .reg_addr       (reg_addr),
        .reg_wdata      (reg_wdata),
        .reg_wr         (reg_wr),
        .reg_rd         (reg_rd),
        .reg_rdata      (reg_rdata),
        .xtal_pulse     (xtal_pulse),
        .xtal_osc_en    (xtal_osc_en),
        .ext_clk_mode   (ext_clk_mode),
        .high_amplitude (high_amplitude),
        .hs_osc_en      (hs_osc_en),
        .ms_osc_en      (ms_osc_en),
        .ls_osc_en      (ls_osc_en),
        .clk_source     (clk_source)
    );
    // ************************************************************
    // Clock and crystal monitor stimulus
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // The crystal pulse is slow enough that the three-flop synchroniser sees every edge.
    always @(posedge mclk) begin
        pcnt       <= pulse_on ? pcnt + 2'h1 : 2'h0;
        xtal_pulse <= pcnt[1];
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        rd(a);
        chk($sformatf("register %0d", a), exp, got);
    endtask
    // Enables show one edge after the write edge, so two edges are allowed.
    task automatic pchk(input logic [7:0] exp);
        repeat (2) @(posedge mclk);
        #1;
        chk("oscillator pins", exp, pins);
    endtask
    task automatic poll(input logic [2:0] a, input logic [7:0] exp);
        got = ~exp;
        for (int i = 0; (i < 20) && (got !== exp); i++) begin
            rd(a);
        end
        chk("polled status", exp, got);
        if (got !== exp) final_report();
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", checks, err_count);
        if ((err_count == 0) && (checks > 0)) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {nrst, reg_wr, reg_rd, pulse_on} = '0;
        {reg_addr, reg_wdata, got, err_count, checks} = '0;
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        pchk(8'h10);
        for (int r = 0; r < 6; r++) rchk(rst_vals[r][10:8], rst_vals[r][7:0]);
        rchk(3'h7, 8'h00);
        for (int r = 0; r < 5; r++) begin
            wr(rows[r][18:16], rows[r][15:8]);
            rchk(rows[r][18:16], rows[r][7:0]);
        end
        pchk(8'h14);
        // Onto the low-speed clock, then a main select change that must be ignored.
        wr(ADDR_SYS, 8'h40);
        poll(ADDR_SYS, 8'hc0);
        pchk(8'h17);
        wr(ADDR_SYS, 8'h50);
        rchk(ADDR_SYS, 8'hc0);
        // Low-speed to middle-speed, then low-speed off.
        wr(ADDR_CTRL, 8'hc2);
        pchk(8'h1f);
        wr(ADDR_SYS, 8'h01);
        poll(ADDR_SYS, 8'h03);
        pchk(8'h1d);
        wr(ADDR_SUB, 8'h00);
        pchk(8'h19);
        wr(ADDR_CTRL, 8'hc3);
        pchk(8'h09);
        // Back to high-speed, then middle-speed off.
        wr(ADDR_CTRL, 8'hc2);
        pchk(8'h19);
        wr(ADDR_SYS, 8'h00);
        poll(ADDR_SYS, 8'h00);
        wr(ADDR_CTRL, 8'hc0);
        pchk(8'h10);
        // Crystal start, shortest code flags after 256 pulses but not 512.
        wr(ADDR_STIME, 8'h00);
        wr(ADDR_CTRL, 8'h40);
        pchk(8'h90);
        pulse_on <= 1'b1;
        repeat (100) @(posedge mclk);
        rchk(ADDR_STAT, 8'h00);
        repeat (1200) @(posedge mclk);
        rchk(ADDR_STAT, 8'h80);
        wr(ADDR_SYS, 8'h10);
        poll(ADDR_SYS, 8'h30);
        pchk(8'h92);
        wr(ADDR_CTRL, 8'h41);
        pchk(8'h82);
        // Stopping the crystal while it drives the clock must not gate it.
        wr(ADDR_CTRL, 8'hc1);
        pchk(8'h82);
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_SYS, 8'h00);
        poll(ADDR_SYS, 8'h00);
        pchk(8'h90);
        wr(ADDR_CTRL, 8'hc0);
        pulse_on <= 1'b0;
        pchk(8'h10);
        rchk(ADDR_STAT, 8'h00);
        // External clock mode reads all flags set.
        wr(ADDR_MODE, 8'hc1);
        pchk(8'h70);
        rchk(ADDR_STAT, 8'hff);
        wr(ADDR_MODE, 8'h00);
        pchk(8'h10);
        // Reset in mid-run.
        wr(ADDR_SUB, 8'h01);
        pchk(8'h14);
        @(posedge mclk);
        nrst <= 1'b0;
        #2;
        chk("pins in reset", 8'h10, pins);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(ADDR_SUB, 8'h00);
        pchk(8'h10);
        final_report();
    end
endmodule // test_clock_source_switch_sequencer
`default_nettype wire
